// file: core/pmrs_pkg.sv
/*
 package for the pll mode and reference select controller: register map,
 state codes, pin and status bundles, timing figures.
 assumes a single 200 mhz clock and an 8 khz frame pulse from the output dividers.
*/
package pmrs_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on a 32-bit axi4-lite slave
	localparam logic [7:0]  REG_STATUS     = 8'h00;
	localparam logic [7:0]  REG_CTRL       = 8'h04;
	localparam logic [7:0]  REG_HOLD_WORD  = 8'h08;
	localparam logic [7:0]  REG_RATES      = 8'h0c;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam int          CTRL_TIE_OK    = 0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// mode pin codes {hi, lo}
	localparam logic [1:0] MODE_NORMAL   = 2'h0;
	localparam logic [1:0] MODE_HOLDOVER = 2'h1;
	localparam logic [1:0] MODE_FREERUN  = 2'h2;
	localparam logic [1:0] MODE_RESERVED = 2'h3;

	// reference rate codes {hi, lo}
	localparam logic [1:0] RATE_19M44 = 2'h0;
	localparam logic [1:0] RATE_8K    = 2'h1;
	localparam logic [1:0] RATE_1M544 = 2'h2;
	localparam logic [1:0] RATE_2M048 = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// timing figures; STORE_FRAMES and LOCK_FRAMES counted in frame pulses
	localparam int FRAME_US      = 125;
	localparam int STORE_MS      = 30;
	localparam int LOCK_S        = 30;
	localparam int STORE_FRAMES  = (STORE_MS * 1000) / FRAME_US;
	localparam int LOCK_FRAMES   = (LOCK_S * 1000000) / FRAME_US;
	localparam int CLK_MHZ       = 200;
	localparam int FAST_LOCK_MS  = 500;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0]
	{
		ST_FREE  = 5'h01,
		ST_NORM  = 5'h02,
		ST_AHOLD = 5'h04,
		ST_HOLD  = 5'h08,
		ST_SHOLD = 5'h10
	} pmrs_state_t;

	// pins from the board, all asynchronous to aclk
	typedef struct packed
	{
		logic mode_pick_hi;
		logic mode_pick_lo;
		logic ref_pick;
		logic hitless_switch_enable;
		logic quick_acquire;
		logic ref_a_rate_hi;
		logic ref_a_rate_lo;
		logic ref_b_rate_hi;
		logic ref_b_rate_lo;
		logic frame_pulse_8k;
		logic ref_input_a;
		logic ref_input_b;
	} pmrs_pins_t;

	// mode indications and controls toward the pll core
	typedef struct packed
	{
		logic normal;
		logic holdover;
		logic freerun;
		logic tie_enable;
		logic fast_lock;
		logic timing_from_osc;
		logic ref_in_use;
		logic lock_window_open;
	} pmrs_stat_t;

endpackage

// file: core/pmrs_ctrl.sv
/*
 operating-mode state controller and reference selection for a dual-input
 network-timing pll, with an axi4-lite register slave.
 assumes the reference valid and lock flags come from logic on aclk, and that
 every board pin is asynchronous and is synchronised here.
*/
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps

module pmrs_ctrl
#(
	parameter int FREQ_W       = 32,
	parameter int STORE_FRAMES = pmrs_pkg::STORE_FRAMES,
	parameter int LOCK_FRAMES  = pmrs_pkg::LOCK_FRAMES
)
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire pmrs_pkg::pmrs_pins_t pins,
	input  wire logic                 ref_in_range,
	input  wire logic                 dpll_locked,
	input  wire logic [FREQ_W-1:0]    freq_word,
	output pmrs_pkg::pmrs_stat_t      stat,
	output logic                      sel_ref,
	output logic                      sel_ref_edge,
	output logic [1:0]                sel_ref_rate,
	output logic [FREQ_W-1:0]         holdover_word,
	output logic                      holdover_apply,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	import pmrs_pkg::*;

	localparam int SC_W = $clog2(STORE_FRAMES + 1);
	localparam int LC_W = $clog2(LOCK_FRAMES + 1);

	pmrs_pins_t        pins_s1_ff;
	pmrs_pins_t        pins_s2_ff;
	logic              fp_d_ff;
	logic              ref_d_ff;
	logic              fp_tick;
	pmrs_state_t       state_ff;
	pmrs_state_t       nxt_state;
	logic [1:0]        mode_code;
	logic              pick_prev_ff;
	logic              pick_changed;
	logic              active_pick_ff;
	logic              tie_ff;
	logic              nxt_tie;
	logic              rate_load_ff;
	logic [1:0]        rate_a_ff;
	logic [1:0]        rate_b_ff;
	logic              sel_ref_ff;
	logic              sel_edge_ff;
	logic [SC_W-1:0]   store_cnt_ff;
	logic              wr_slot_ff;
	logic [FREQ_W-1:0] slot_ff [2];
	logic [FREQ_W-1:0] hold_word_ff;
	logic              hold_apply_ff;
	logic [LC_W-1:0]   lock_cnt_ff;
	logic [31:0]       ctrl_ff;
	logic              holding;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; stage one feeds stage two only. kept out of reset so
	// that the rate pins are already settled when they are caught at release
	always_ff @(posedge aclk)
	begin
		pins_s1_ff <= pins;
		pins_s2_ff <= pins_s1_ff;
	end

	// held high in reset: a pulse already under way at release is no edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fp_d_ff <= 1'b1;
		else
			fp_d_ff <= pins_s2_ff.frame_pulse_8k;
	end

	assign fp_tick   = pins_s2_ff.frame_pulse_8k & ~fp_d_ff;
	assign mode_code = {pins_s2_ff.mode_pick_hi, pins_s2_ff.mode_pick_lo};

	////////////////////////////////////////////////////////////////////////
	// select-pin change seen between successive frame pulses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pick_prev_ff <= 1'b0;
		else if (fp_tick)
			pick_prev_ff <= pins_s2_ff.ref_pick;
	end

	assign pick_changed = pins_s2_ff.ref_pick != pick_prev_ff;

	////////////////////////////////////////////////////////////////////////
	// next state and hitless-switch enable
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_FREE:
			begin
				if (mode_code == MODE_NORMAL)
					nxt_state = ST_NORM;
				else if (mode_code == MODE_HOLDOVER)
					nxt_state = ST_HOLD;
			end
			ST_NORM:
			begin
				if (pick_changed)
					nxt_state = ST_SHOLD;
				else if (!ref_in_range)
					nxt_state = ST_AHOLD;
				else if (mode_code == MODE_HOLDOVER)
					nxt_state = ST_HOLD;
				else if (mode_code == MODE_FREERUN)
					nxt_state = ST_FREE;
			end
			ST_AHOLD:
			begin
				if (mode_code == MODE_HOLDOVER)
					nxt_state = ST_HOLD;
				else if (mode_code == MODE_FREERUN)
					nxt_state = ST_FREE;
				else if (pick_changed)
					nxt_state = ST_SHOLD;
				else if (ref_in_range && mode_code == MODE_NORMAL)
					nxt_state = ST_NORM;
			end
			ST_HOLD:
			begin
				if (mode_code == MODE_NORMAL)
					nxt_state = ST_NORM;
				else if (mode_code == MODE_FREERUN)
					nxt_state = ST_FREE;
			end
			ST_SHOLD:
			begin
				if (mode_code == MODE_HOLDOVER)
					nxt_state = ST_HOLD;
				else if (mode_code == MODE_FREERUN)
					nxt_state = ST_FREE;
				else if (!pick_changed && mode_code == MODE_NORMAL)
					nxt_state = ST_NORM;
			end
			default:
				nxt_state = ST_FREE;
		endcase
		if (mode_code == MODE_RESERVED)
			nxt_state = state_ff;
	end

	always_comb
	begin
		nxt_tie = tie_ff;
		if (nxt_state != state_ff)
		begin
			if (nxt_state == ST_NORM && state_ff != ST_FREE)
				nxt_tie = pins_s2_ff.hitless_switch_enable & ctrl_ff[CTRL_TIE_OK];
			else
				nxt_tie = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operating state, advanced on frame pulses only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= ST_FREE;
			tie_ff   <= 1'b0;
		end
		else if (fp_tick)
		begin
			state_ff <= nxt_state;
			tie_ff   <= nxt_tie;
		end
	end

	// the new reference takes over when short holdover ends in normal mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			active_pick_ff <= 1'b0;
		else if (rate_load_ff)
			active_pick_ff <= pins_s2_ff.ref_pick;
		else if (fp_tick && state_ff == ST_SHOLD && nxt_state == ST_NORM)
			active_pick_ff <= pins_s2_ff.ref_pick;
	end

	////////////////////////////////////////////////////////////////////////
	// rate codes caught once after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rate_load_ff <= 1'b1;
		else
			rate_load_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rate_a_ff <= RATE_19M44;
			rate_b_ff <= RATE_19M44;
		end
		else if (rate_load_ff)
		begin
			rate_a_ff <= {pins_s2_ff.ref_a_rate_hi, pins_s2_ff.ref_a_rate_lo};
			rate_b_ff <= {pins_s2_ff.ref_b_rate_hi, pins_s2_ff.ref_b_rate_lo};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// selected reference and its active edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_ref_ff  <= 1'b0;
			ref_d_ff    <= 1'b0;
			sel_edge_ff <= 1'b0;
		end
		else
		begin
			sel_ref_ff <= active_pick_ff ? pins_s2_ff.ref_input_b
						: pins_s2_ff.ref_input_a;
			ref_d_ff   <= sel_ref_ff;
			if (sel_ref_rate == RATE_19M44)
				sel_edge_ff <= sel_ref_ff & ~ref_d_ff;
			else
				sel_edge_ff <= ~sel_ref_ff & ref_d_ff;
		end
	end

	assign sel_ref_rate = active_pick_ff ? rate_b_ff : rate_a_ff;
	assign sel_ref      = sel_ref_ff;
	assign sel_ref_edge = sel_edge_ff & (state_ff != ST_FREE);

	////////////////////////////////////////////////////////////////////////
	// holdover frequency storage, two slots written in turn
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			store_cnt_ff <= '0;
			wr_slot_ff   <= 1'b0;
			slot_ff[0]   <= '0;
			slot_ff[1]   <= '0;
		end
		else if (fp_tick && state_ff == ST_NORM && dpll_locked)
		begin
			if (store_cnt_ff == SC_W'(STORE_FRAMES - 1))
			begin
				store_cnt_ff        <= '0;
				slot_ff[wr_slot_ff] <= freq_word;
				wr_slot_ff          <= ~wr_slot_ff;
			end
			else
				store_cnt_ff <= store_cnt_ff + SC_W'(1);
		end
	end

	assign holding = state_ff == ST_AHOLD || state_ff == ST_HOLD || state_ff == ST_SHOLD;

	// the slot awaiting the next write is the older one, 30 to 60 ms old
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hold_word_ff  <= '0;
			hold_apply_ff <= 1'b0;
		end
		else
		begin
			hold_apply_ff <= 1'b0;
			if (fp_tick && !holding && nxt_state != state_ff &&
				(nxt_state == ST_AHOLD || nxt_state == ST_HOLD || nxt_state == ST_SHOLD))
			begin
				hold_word_ff  <= slot_ff[wr_slot_ff];
				hold_apply_ff <= 1'b1;
			end
		end
	end

	assign holdover_word  = hold_word_ff;
	assign holdover_apply = hold_apply_ff;

	////////////////////////////////////////////////////////////////////////
	// lock deadline after reset, counted in normal mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lock_cnt_ff <= '0;
		else if (fp_tick && state_ff == ST_NORM && lock_cnt_ff != LC_W'(LOCK_FRAMES))
			lock_cnt_ff <= lock_cnt_ff + LC_W'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// status toward the pll core
	always_comb
	begin
		stat                  = '0;
		stat.normal           = state_ff == ST_NORM;
		stat.holdover         = holding;
		stat.freerun          = state_ff == ST_FREE;
		stat.tie_enable       = tie_ff;
		stat.fast_lock        = (state_ff == ST_NORM) & pins_s2_ff.quick_acquire;
		stat.timing_from_osc  = state_ff == ST_FREE;
		stat.ref_in_use       = state_ff == ST_NORM;
		stat.lock_window_open = lock_cnt_ff != LC_W'(LOCK_FRAMES);
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write side
	logic       aw_held_ff;
	logic       w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic       bvalid_ff;
	logic [1:0] bresp_ff;
	logic       do_write;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				unique case ({aw_addr_ff[7:2], 2'h0})
					REG_STATUS, REG_CTRL, REG_HOLD_WORD, REG_RATES:
						bresp_ff <= RESP_OKAY;
					default:
						bresp_ff <= RESP_SLVERR;
				endcase
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_ff <= CTRL_RESET;
		else if (do_write && {aw_addr_ff[7:2], 2'h0} == REG_CTRL && w_strb_ff[0])
			ctrl_ff <= {31'h0, w_data_ff[CTRL_TIE_OK]};
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read side
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= RESP_OKAY;
			rdata_ff  <= '0;
			unique case ({s_axi_araddr[7:2], 2'h0})
				REG_STATUS:
					rdata_ff <= {16'h0, 3'h0, state_ff, stat};
				REG_CTRL:
					rdata_ff <= ctrl_ff;
				REG_HOLD_WORD:
					rdata_ff <= 32'(hold_word_ff);
				REG_RATES:
					rdata_ff <= {27'h0, active_pick_ff, rate_b_ff, rate_a_ff};
				default:
					rresp_ff <= RESP_SLVERR;
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

endmodule

// file: bench/pmrs_ctrl_props.sv
/*
 checker for the mode controller, bound to pmrs_ctrl.
 assumes one clock domain, synchronous active-low reset.
*/
`timescale 1ns/100ps
module pmrs_ctrl_props
(
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire pmrs_pkg::pmrs_pins_t pins,
	input wire pmrs_pkg::pmrs_stat_t stat,
	input wire logic                 sel_ref_edge,
	input wire logic                 holdover_apply,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic [1:0]           s_axi_bresp,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic [31:0]          s_axi_rdata
);
	import pmrs_pkg::*;
	logic       fp_d_ff;
	logic [3:0] since_fp_ff;
	logic [2:0] rsv_cnt_ff;

	// cycles since the frame pulse pin rose, saturating
	always_ff @(posedge aclk)
	begin
		fp_d_ff <= pins.frame_pulse_8k;
		if (!aresetn)
			since_fp_ff <= 4'hf;
		else if (pins.frame_pulse_8k && !fp_d_ff)
			since_fp_ff <= 4'h0;
		else if (since_fp_ff != 4'hf)
			since_fp_ff <= since_fp_ff + 4'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !(pins.mode_pick_hi && pins.mode_pick_lo))
			rsv_cnt_ff <= 3'h0;
		else if (rsv_cnt_ff != 3'h7)
			rsv_cnt_ff <= rsv_cnt_ff + 3'h1;
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_one_mode:
		assert property ($onehot({stat.normal, stat.holdover, stat.freerun}))
		else $error("mode outputs not one-hot");
	a_frame_only:
		assert property ($changed(stat[7:5]) |-> since_fp_ff >= 4'h1 && since_fp_ff <= 4'h7)
		else $error("mode changed away from a frame pulse");
	a_tie_rise:
		assert property ($rose(stat.tie_enable) |-> $rose(stat.normal) && !$past(stat.freerun))
		else $error("tie enabled outside entry to normal");
	a_tie_leave:
		assert property ($changed(stat[7:5]) && !stat.normal |-> !stat.tie_enable)
		else $error("tie left on after transition");
	a_fast_norm:
		assert property (stat.fast_lock |-> stat.normal)
		else $error("fast lock outside normal");
	a_free_osc:
		assert property (stat.freerun && $past(stat.freerun, 2) |-> stat.timing_from_osc
			&& !sel_ref_edge)
		else $error("freerun not on oscillator");
	a_hold_load:
		assert property (holdover_apply |-> $rose(stat.holdover))
		else $error("holdover word loaded off entry");
	a_rsv_keep:
		assert property (stat.freerun && rsv_cnt_ff == 3'h7 |=> stat.freerun)
		else $error("reserved code left freerun");
	a_b_stand:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_stand:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");

	c_short: cover property ($rose(stat.holdover) ##[1:200] $rose(stat.normal));
	c_tie_on: cover property ($rose(stat.tie_enable));
	c_fast: cover property (stat.fast_lock);
endmodule

// file: bench/pmrs_board.sv
/*
 board model: frame pulse and two reference clocks.
 assumes a free-running aclk; no reset of its own.
*/
`timescale 1ns/100ps
module pmrs_board
#(
	parameter int FP_PERIOD = 40
)
(
	input  wire logic aclk,
	output logic      frame_pulse_8k,
	output logic      ref_input_a,
	output logic      ref_input_b
);
	logic [7:0] fp_cnt_ff = 8'h00;
	logic [3:0] ref_cnt_ff = 4'h0;

	always_ff @(posedge aclk)
	begin
		if (fp_cnt_ff == 8'(FP_PERIOD - 1))
			fp_cnt_ff <= 8'h00;
		else
			fp_cnt_ff <= fp_cnt_ff + 8'h01;
	end

	always_ff @(posedge aclk)
	begin
		ref_cnt_ff <= ref_cnt_ff + 4'h1;
	end

	// pulse high four cycles at each frame start
	assign frame_pulse_8k = fp_cnt_ff < 8'h04;
	assign ref_input_a    = ref_cnt_ff[1];
	assign ref_input_b    = ref_cnt_ff[2];
endmodule

// file: bench/pmrs_ctrl_tb.sv
/*
 self-checking bench for pmrs_ctrl: mode table, then hand tests.
 assumes pmrs_board for frame pulse and references.
*/
`timescale 1ns/100ps
module pmrs_ctrl_tb;
	import pmrs_pkg::*;
	logic        aclk;
	logic        aresetn;
	pmrs_pins_t  bp;
	pmrs_pins_t  pins;
	logic        fp;
	logic        ra;
	logic        rb;
	logic        ref_in_range;
	logic        dpll_locked;
	logic [31:0] freq_word;
	pmrs_stat_t  stat;
	logic        sel_ref;
	logic        sel_ref_edge;
	logic [1:0]  sel_ref_rate;
	logic [31:0] holdover_word;
	logic        holdover_apply;
	logic [7:0]  s_axi_awaddr;
	logic [7:0]  s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [31:0] s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          n_fail;
	int          n_tests;
	int          cyc = 0;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          ne;
	int          nh;
	logic [4:0]  rows [8];

	assign pins = {bp[11:3], fp, ra, rb};

	pmrs_board #(.FP_PERIOD(40)) pmrs_board_inst
	(.aclk, .frame_pulse_8k(fp), .ref_input_a(ra), .ref_input_b(rb));

	pmrs_ctrl #(.STORE_FRAMES(4), .LOCK_FRAMES(20)) pmrs_ctrl_inst
	(
		.aclk, .aresetn, .pins, .ref_in_range, .dpll_locked, .freq_word, .stat, .sel_ref,
		.sel_ref_edge, .sel_ref_rate, .holdover_word, .holdover_apply, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready
	);

	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// two frame ticks catch a pin change for sure; eight cycles let it land
	task automatic frames(input int n);
		repeat (n) @(posedge fp);
		repeat (8) @(posedge aclk);
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// active-edge pulses and high cycles of the selected reference over n cycles
	task automatic ref_count(input int n, output int e, output int h);
		e = 0;
		h = 0;
		repeat (n)
		begin
			@(posedge aclk);
			e += int'(sel_ref_edge);
			h += int'(sel_ref);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	initial
	begin
		n_fail = 0;
		n_tests = 0;
		bp = '0;
		bp.mode_pick_hi = 1'h1;
		{bp.ref_b_rate_hi, bp.ref_b_rate_lo} = RATE_2M048;
		aresetn = 1'h0;
		ref_in_range = 1'h1;
		dpll_locked = 1'h1;
		freq_word = 32'h5a5a_0001;
		s_axi_wstrb = 4'hf;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		// {mode code, normal, holdover, freerun}
		rows = '{5'h04, 5'h0a, 5'h04, 5'h11, 5'h19, 5'h0a, 5'h1a, 5'h11};
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk("stat after reset", 32'h25, {24'h0, stat});
		axr(REG_RATES, rd, rs);
		chk("rates", 32'h0c, rd);
		foreach (rows[i])
		begin
			{bp.mode_pick_hi, bp.mode_pick_lo} <= rows[i][4:3];
			frames(2);
			chk("mode row", {29'h0, rows[i][2:0]}, {29'h0, stat[7:5]});
			chk("tie row", 32'h0, {31'h0, stat.tie_enable});
		end
		bp.hitless_switch_enable <= 1'h1;
		bp.quick_acquire <= 1'h1;
		{bp.mode_pick_hi, bp.mode_pick_lo} <= MODE_NORMAL;
		frames(12);
		chk("free to normal", 32'h11, {27'h0, stat[7:3]});
		ref_in_range <= 1'h0;
		frames(2);
		chk("auto hold", 32'h08, {27'h0, stat[7:3]});
		chk("hold word", 32'h5a5a_0001, holdover_word);
		axr(REG_STATUS, rd, rs);
		chk("auto hold state", 32'h04, {27'h0, rd[12:8]});
		bp.ref_pick <= 1'h1;
		ref_in_range <= 1'h1;
		frames(1);
		axr(REG_STATUS, rd, rs);
		chk("short hold state", 32'h10, {27'h0, rd[12:8]});
		frames(1);
		chk("short to normal", 32'h13, {27'h0, stat[7:3]});
		axr(REG_RATES, rd, rs);
		chk("active pick", 32'h1c, rd);
		chk("active rate", 32'h3, {30'h0, sel_ref_rate});
		ref_count(64, ne, nh);
		chk("edge count b", 32'h8, ne);
		chk("ref highs b", 32'h20, nh);
		bp.ref_pick <= 1'h0;
		frames(1);
		chk("pick in normal", 32'h08, {27'h0, stat[7:3]});
		frames(1);
		chk("pick settled", 32'h13, {27'h0, stat[7:3]});
		axw(REG_CTRL, 32'h0, rs);
		chk("ctrl resp", {30'h0, RESP_OKAY}, {30'h0, rs});
		axr(REG_CTRL, rd, rs);
		chk("ctrl read", 32'h0, rd);
		{bp.mode_pick_hi, bp.mode_pick_lo} <= MODE_HOLDOVER;
		frames(2);
		{bp.mode_pick_hi, bp.mode_pick_lo} <= MODE_NORMAL;
		frames(2);
		chk("gated tie", 32'h11, {27'h0, stat[7:3]});
		axw(REG_CTRL, CTRL_RESET, rs);
		axr(8'h10, rd, rs);
		chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
		chk("unmapped data", 32'h0, rd);
		axw(8'h10, 32'hffff_ffff, rs);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
		axw(REG_STATUS, 32'hffff_ffff, rs);
		chk("ro write", {30'h0, RESP_OKAY}, {30'h0, rs});
		{bp.mode_pick_hi, bp.mode_pick_lo} <= MODE_FREERUN;
		{bp.ref_a_rate_hi, bp.ref_a_rate_lo} <= RATE_8K;
		{bp.ref_b_rate_hi, bp.ref_b_rate_lo} <= RATE_1M544;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk("stat second reset", 32'h25, {24'h0, stat});
		axr(REG_RATES, rd, rs);
		chk("new rates", 32'h09, rd);
		ref_count(64, ne, nh);
		chk("edge count free", 32'h0, ne);
		chk("ref highs a", 32'h20, nh);
		end_of_test();
	end
endmodule

bind pmrs_ctrl pmrs_ctrl_props pmrs_ctrl_props_inst
(
	.aclk, .aresetn, .pins, .stat, .sel_ref_edge, .holdover_apply, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
